// file: frp_cmd_decoder.sv
// command decoder for resume, write enable latch and sector protection
`timescale 1ns/1ps
`default_nettype none
module frp_cmd_decoder (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic csN,
    input wire logic sck,
    input wire logic mosi,
    input wire logic engineBusy,
    input wire logic engineIsErase,
    input wire logic engineDone,
    input wire logic [frp_pkg::SECTOR_IDX_W-1:0] opSector,
    output logic [7:0] statusByte,
    output logic [frp_pkg::SECTOR_COUNT-1:0] sectorProtect,
    output logic programAllowed,
    output logic eraseAllowed,
    output logic suspendReq,
    output logic resumeReq,
    output logic resumeIsErase,
    output logic writeCmdAllowed
);
    import frp_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic rstMeta_ff;
    logic rstSync_ff;
    logic rstN;
    logic csSync;
    logic sckSync;
    logic mosiSync;
    logic sckPrev_ff;
    logic csPrev_ff;
    logic [31:0] shiftData;
    logic [5:0] bitCount;
    logic selActive;
    logic sckRise;
    logic deselect;
    logic [7:0] opcode;
    logic [7:0] opcode_ff;
    logic [7:0] nxt_opcode;
    // reset release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end
    // everything below runs from the released copy, never from the pin
    assign rstN = rstSync_ff;
    frp_sync uCsSync (.clk(clk), .rstN(rstN), .din(~csN), .dout(csSync));
    frp_sync uSckSync (.clk(clk), .rstN(rstN), .din(sck), .dout(sckSync));
    frp_sync uMosiSync (.clk(clk), .rstN(rstN), .din(mosi), .dout(mosiSync));
    assign selActive = csSync;
    assign sckRise = sckSync & ~sckPrev_ff;
    assign deselect = csPrev_ff & ~csSync;
    frp_shifter uShifter (
        .clk(clk),
        .rstN(rstN),
        .selActive(selActive),
        .sckRise(sckRise),
        .mosiBit(mosiSync),
        .shiftData(shiftData),
        .bitCount(bitCount)
    );
    // latch the opcode once eight bits are in
    assign opcode = opcode_ff;
    always_comb begin
        nxt_opcode = opcode_ff;
        if (!selActive) begin
            nxt_opcode = 8'h00;
        end else if (sckRise && bitCount == 6'h07) begin
            nxt_opcode = {shiftData[6:0], mosiSync};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // frame qualification
    function automatic logic byteAligned(input logic [5:0] cnt);
        byteAligned = (cnt[2:0] == 3'h0) || (cnt == 6'h3F);
    endfunction
    logic opComplete;
    logic addrComplete;
    logic [SECTOR_IDX_W-1:0] addrSector;
    logic [SECTOR_IDX_W-1:0] addrSector_ff;
    logic [SECTOR_IDX_W-1:0] nxt_addrSector;
    logic lockData_ff;
    logic nxt_lockData;
    // opcode whole, frame ends on a byte boundary
    assign opComplete = (bitCount >= 6'h08) && byteAligned(bitCount);
    assign addrComplete = (bitCount >= 6'h20) && byteAligned(bitCount);
    assign addrSector = addrSector_ff;
    always_comb begin
        nxt_addrSector = addrSector_ff;
        if (sckRise && {1'b0, bitCount[4:0]} == {1'b0, BITS_ADDR_DONE} && bitCount[5] == 1'b0) begin
            nxt_addrSector = shiftData[SECTOR_ADDR_LSB-1 +: SECTOR_IDX_W];
        end
    end
    // capture data bit 7; before the last shift it sits one place lower
    always_comb begin
        nxt_lockData = lockData_ff;
        if (sckRise && bitCount == 6'h0F) begin
            nxt_lockData = shiftData[LOCK_BIT_POS - 1];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // status and protection state
    logic wel_ff;
    logic nxt_wel;
    logic lock_ff;
    logic nxt_lock;
    logic ps_ff;
    logic nxt_ps;
    logic es_ff;
    logic nxt_es;
    logic [SECTOR_COUNT-1:0] prot_ff;
    logic [SECTOR_COUNT-1:0] nxt_prot;
    frp_eng_t eng_ff;
    frp_eng_t nxt_eng;
    logic [15:0] resCnt_ff;
    logic [15:0] nxt_resCnt;
    logic resumeErase_ff;
    logic nxt_resumeErase;
    logic nxt_suspendReq;
    logic suspendReq_ff;
    logic nxt_resumeReq;
    logic resumeReq_ff;
    always_comb begin
        nxt_wel = wel_ff;
        nxt_lock = lock_ff;
        nxt_ps = ps_ff;
        nxt_es = es_ff;
        nxt_prot = prot_ff;
        nxt_eng = eng_ff;
        nxt_resCnt = resCnt_ff;
        nxt_resumeErase = resumeErase_ff;
        nxt_suspendReq = 1'b0;
        nxt_resumeReq = 1'b0;
        // resumed work is running once the latency counter ends; busy holds until engineDone
        case (eng_ff)
            ENG_IDLE: begin
                if (engineBusy) begin
                    nxt_eng = ENG_RUNNING;
                end
            end
            ENG_RESUMING: begin
                if (resCnt_ff == 16'h0000) begin
                    nxt_eng = ENG_RUNNING;
                end else begin
                    nxt_resCnt = resCnt_ff - 16'h0001;
                end
            end
            ENG_RUNNING: begin
                if (engineDone) begin
                    nxt_eng = ENG_IDLE;
                end
            end
            default: begin
                nxt_eng = ENG_IDLE;
            end
        endcase
        if (deselect && opComplete) begin
            if (opcode == OP_RESUME) begin
                if (ps_ff) begin
                    nxt_ps = 1'b0;
                    nxt_resumeErase = 1'b0;
                    nxt_resumeReq = 1'b1;
                    nxt_eng = ENG_RESUMING;
                    nxt_resCnt = 16'(RESUME_CYCLES - 1);
                end else if (es_ff) begin
                    nxt_es = 1'b0;
                    nxt_resumeErase = 1'b1;
                    nxt_resumeReq = 1'b1;
                    nxt_eng = ENG_RESUMING;
                    nxt_resCnt = 16'(RESUME_CYCLES - 1);
                end
            end else if (opcode == OP_SUSPEND) begin
                if (eng_ff == ENG_RUNNING && engineBusy) begin
                    nxt_suspendReq = 1'b1;
                    nxt_ps = ~engineIsErase | ps_ff;
                    nxt_es = engineIsErase | es_ff;
                    nxt_eng = ENG_IDLE;
                end
            end else if (opcode == OP_WREN) begin
                nxt_wel = 1'b1;
            end else if (opcode == OP_WRDI) begin
                nxt_wel = 1'b0;
            end else if (opcode == OP_PROTECT || opcode == OP_UNPROTECT) begin
                if (wel_ff && !lock_ff && addrComplete) begin
                    nxt_prot[addrSector] = (opcode == OP_PROTECT);
                end
                nxt_wel = 1'b0;
            end else if (opcode == OP_STATUS_WR) begin
                if (wel_ff && bitCount >= 6'h10) begin
                    nxt_lock = lockData_ff;
                end
                nxt_wel = 1'b0;
            end
        end
        // misaligned protect frame: bit kept, latch still cleared
        if (deselect && !opComplete && bitCount >= 6'h08 && (opcode == OP_PROTECT || opcode == OP_UNPROTECT)) begin
            nxt_wel = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wel_ff <= 1'b0;
            lock_ff <= 1'b0;
            ps_ff <= 1'b0;
            es_ff <= 1'b0;
            prot_ff <= PROTECT_RESET;
            eng_ff <= ENG_IDLE;
            resCnt_ff <= 16'h0000;
            resumeErase_ff <= 1'b0;
            suspendReq_ff <= 1'b0;
            resumeReq_ff <= 1'b0;
            addrSector_ff <= '0;
            lockData_ff <= 1'b0;
            opcode_ff <= 8'h00;
            sckPrev_ff <= 1'b0;
            csPrev_ff <= 1'b0;
        end else begin
            wel_ff <= nxt_wel;
            lock_ff <= nxt_lock;
            ps_ff <= nxt_ps;
            es_ff <= nxt_es;
            prot_ff <= nxt_prot;
            eng_ff <= nxt_eng;
            resCnt_ff <= nxt_resCnt;
            resumeErase_ff <= nxt_resumeErase;
            suspendReq_ff <= nxt_suspendReq;
            resumeReq_ff <= nxt_resumeReq;
            addrSector_ff <= nxt_addrSector;
            lockData_ff <= nxt_lockData;
            opcode_ff <= nxt_opcode;
            sckPrev_ff <= sckSync;
            csPrev_ff <= csSync;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // outputs; busy covers both the resume latency and a running operation
    always_comb begin
        statusByte = 8'h00;
        statusByte[LOCK_BIT_POS] = lock_ff;
        statusByte[STAT_PS_POS] = ps_ff;
        statusByte[STAT_ES_POS] = es_ff;
        statusByte[STAT_WEL_POS] = wel_ff;
        statusByte[STAT_BUSY_POS] = (eng_ff != ENG_IDLE);
    end
    assign sectorProtect = prot_ff;
    // protected sector blocks program and erase
    assign programAllowed = ~prot_ff[opSector] & wel_ff;
    assign eraseAllowed = ~prot_ff[opSector] & wel_ff;
    assign writeCmdAllowed = wel_ff;
    assign suspendReq = suspendReq_ff;
    assign resumeReq = resumeReq_ff;
    assign resumeIsErase = resumeErase_ff;
endmodule // frp_cmd_decoder
`default_nettype wire

// file: frp_cmd_decoder_bench.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module frp_cmd_decoder_bench;
    import frp_pkg::*;
    logic clk, reset_n, csN, sck, mosi, engineBusy, engineIsErase, engineDone;
    logic [SECTOR_IDX_W-1:0] opSector;
    logic [7:0] statusByte;
    logic [SECTOR_COUNT-1:0] sectorProtect;
    logic programAllowed, eraseAllowed, suspendReq, resumeReq, resumeIsErase, writeCmdAllowed;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int nResume = 0;
    int nSuspend = 0;
    frp_host_model u_host (.clk(clk), .csN(csN), .sck(sck), .mosi(mosi));
    frp_cmd_decoder u_dut (.clk(clk), .reset_n(reset_n), .csN(csN), .sck(sck), .mosi(mosi),
        .engineBusy(engineBusy), .engineIsErase(engineIsErase), .engineDone(engineDone), .opSector(opSector),
        .statusByte(statusByte), .sectorProtect(sectorProtect), .programAllowed(programAllowed),
        .eraseAllowed(eraseAllowed), .suspendReq(suspendReq), .resumeReq(resumeReq),
        .resumeIsErase(resumeIsErase), .writeCmdAllowed(writeCmdAllowed));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // a hung frame or wait ends the run as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [31:0] d, input int n, input logic [7:0] es, input logic [15:0] ep);
        u_host.send(d, n);
        chk("statusByte", {8'h00, es}, {8'h00, statusByte});
        chk("sectorProtect", ep, sectorProtect);
    endtask
    task automatic wren();
        u_host.send(32'h06000000, 8);
    endtask
    // engine finishes its operation
    task automatic done();
        engineDone = 1'b1;
        @(negedge clk);
        engineDone = 1'b0;
        engineBusy = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // engine runs, host suspends it, engine stops on the request pulse
    task automatic susp(input logic erase, input logic [7:0] es);
        engineIsErase = erase;
        engineBusy = 1'b1;
        fork
            cmd(32'hB0000000, 8, es, 16'hFFFF);
            begin
                @(posedge suspendReq);
                @(negedge clk);
                engineBusy = 1'b0;
            end
        join
    endtask
    // count one-cycle request pulses away from the edge that launches them
    always @(negedge clk) begin
        if (resumeReq === 1'b1) begin
            nResume++;
        end
        if (suspendReq === 1'b1) begin
            nSuspend++;
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        engineBusy = 1'b0;
        engineIsErase = 1'b0;
        engineDone = 1'b0;
        opSector = 4'h3;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        chk("statusByte", 16'h0000, {8'h00, statusByte});
        chk("sectorProtect", 16'hFFFF, sectorProtect);
        cmd(32'h06000000, 7, 8'h00, 16'hFFFF);
        cmd(32'h06000000, 8, 8'h02, 16'hFFFF);
        cmd(32'h04000000, 12, 8'h02, 16'hFFFF);
        cmd(32'h04A50000, 16, 8'h00, 16'hFFFF);
        $display("test latch done");
        cmd(32'h36030000, 32, 8'h00, 16'hFFFF);
        wren();
        cmd(32'h39030000, 32, 8'h00, 16'hFFF7);
        wren();
        chk("programAllowed", 16'h0001, {15'h0000, programAllowed});
        chk("eraseAllowed", 16'h0001, {15'h0000, eraseAllowed});
        opSector = 4'h4;
        repeat (3) @(negedge clk);
        chk("programAllowed", 16'h0000, {15'h0000, programAllowed});
        chk("writeCmdAllowed", 16'h0001, {15'h0000, writeCmdAllowed});
        cmd(32'h36030000, 24, 8'h00, 16'hFFF7);
        wren();
        cmd(32'h36030000, 20, 8'h00, 16'hFFF7);
        wren();
        cmd(32'h01800000, 16, 8'h80, 16'hFFF7);
        wren();
        cmd(32'h36030000, 32, 8'h80, 16'hFFF7);
        wren();
        cmd(32'h01000000, 16, 8'h00, 16'hFFF7);
        wren();
        cmd(32'h36030000, 32, 8'h00, 16'hFFFF);
        $display("test protection done");
        cmd(32'hD0000000, 8, 8'h00, 16'hFFFF);
        susp(1'b0, 8'h08);
        cmd(32'hD0000000, 4, 8'h08, 16'hFFFF);
        cmd(32'hD0FF0000, 16, 8'h01, 16'hFFFF);
        engineBusy = 1'b1;
        cmd(32'hB0000000, 8, 8'h01, 16'hFFFF);
        repeat (RESUME_CYCLES) @(negedge clk);
        chk("statusByte", 16'h0001, {8'h00, statusByte});
        done();
        chk("statusByte", 16'h0000, {8'h00, statusByte});
        $display("test resume done");
        susp(1'b1, 8'h04);
        susp(1'b0, 8'h0C);
        cmd(32'hD0000000, 8, 8'h05, 16'hFFFF);
        chk("resumeIsErase", 16'h0000, {15'h0000, resumeIsErase});
        repeat (RESUME_CYCLES) @(negedge clk);
        done();
        chk("statusByte", 16'h0004, {8'h00, statusByte});
        cmd(32'hD0000000, 8, 8'h01, 16'hFFFF);
        chk("resumeIsErase", 16'h0001, {15'h0000, resumeIsErase});
        repeat (RESUME_CYCLES) @(negedge clk);
        done();
        chk("statusByte", 16'h0000, {8'h00, statusByte});
        chk("resumeReq", 16'h0003, 16'(nResume));
        chk("suspendReq", 16'h0003, 16'(nSuspend));
        $display("test double suspend done");
        wrap_up();
    end
endmodule // frp_cmd_decoder_bench
`default_nettype wire

// file: frp_cmd_decoder_props.sv
// port-level properties of the command decoder
`timescale 1ns/1ps
`default_nettype none
module frp_cmd_props
    import frp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic csN,
    input wire logic sck,
    input wire logic mosi,
    input wire logic engineBusy,
    input wire logic engineIsErase,
    input wire logic engineDone,
    input wire logic [SECTOR_IDX_W-1:0] opSector,
    input wire logic [7:0] statusByte,
    input wire logic [SECTOR_COUNT-1:0] sectorProtect,
    input wire logic programAllowed,
    input wire logic eraseAllowed,
    input wire logic suspendReq,
    input wire logic resumeReq,
    input wire logic resumeIsErase,
    input wire logic writeCmdAllowed
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_resume_pulse_one: assert property (resumeReq |=> !resumeReq)
        else $error("resumeReq held past one cycle");
    a_resume_clears_ps: assert property (resumeReq && !resumeIsErase |=> !statusByte[STAT_PS_POS])
        else $error("program-suspended flag kept after resume");
    a_resume_no_susp: assert property (resumeReq |=> !suspendReq [*8])
        else $error("suspend issued while resuming");
    a_busy_resuming: assert property (resumeReq |=> statusByte[STAT_BUSY_POS] [*8])
        else $error("busy dropped during resume");
    a_prot_needs_wel: assert property ($changed(sectorProtect) |-> $past(statusByte[STAT_WEL_POS]))
        else $error("protection changed without latch");
    a_prot_clears_wel: assert property ($changed(sectorProtect) |-> !statusByte[STAT_WEL_POS])
        else $error("latch kept after protection change");
    a_prot_at_deselect: assert property ($changed(sectorProtect) |-> $past(csN, 3))
        else $error("protection changed inside a frame");
    a_lock_freezes: assert property ($past(statusByte[LOCK_BIT_POS]) |-> $stable(sectorProtect))
        else $error("protection changed while locked");
    a_allow_follows: assert property (programAllowed |-> writeCmdAllowed && !sectorProtect[opSector])
        else $error("program allowed on protected sector");
    a_wel_mirror: assert property (writeCmdAllowed == statusByte[STAT_WEL_POS])
        else $error("write allow differs from latch");
endmodule // frp_cmd_props
bind frp_cmd_decoder frp_cmd_props u_props (.clk(clk), .reset_n(reset_n), .csN(csN), .sck(sck), .mosi(mosi),
    .engineBusy(engineBusy), .engineIsErase(engineIsErase), .engineDone(engineDone), .opSector(opSector),
    .statusByte(statusByte), .sectorProtect(sectorProtect), .programAllowed(programAllowed),
    .eraseAllowed(eraseAllowed), .suspendReq(suspendReq), .resumeReq(resumeReq),
    .resumeIsErase(resumeIsErase), .writeCmdAllowed(writeCmdAllowed));
`default_nettype wire

// file: frp_host_model.sv
// host serial controller that shifts command frames
`timescale 1ns/1ps
`default_nettype none
module frp_host_model (
    input wire logic clk,
    output logic csN,
    output logic sck,
    output logic mosi
);
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic send(input logic [31:0] data, input int nbits);
        csN = 1'b0;
        pause(4);
        for (int i = 0; i < nbits; i++) begin
            mosi = data[31-i];
            pause(4);
            sck = 1'b1;
            pause(4);
            sck = 1'b0;
        end
        pause(4);
        csN = 1'b1;
        // no stale bit left on the data line between frames
        mosi = ~mosi;
        pause(14);
    endtask
endmodule // frp_host_model
`default_nettype wire

// file: frp_pkg.sv
// shared constants for the resume and write-protect command decoder
package frp_pkg;
    localparam logic [7:0] OP_RESUME = 8'hD0;
    localparam logic [7:0] OP_SUSPEND = 8'hB0;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_PROTECT = 8'h36;
    localparam logic [7:0] OP_UNPROTECT = 8'h39;
    localparam logic [7:0] OP_STATUS_WR = 8'h01;
    localparam int SECTOR_COUNT = 16;
    localparam int SECTOR_IDX_W = 4;
    localparam int SECTOR_ADDR_LSB = 16;
    localparam logic [SECTOR_COUNT-1:0] PROTECT_RESET = 16'hFFFF;
    localparam int LOCK_BIT_POS = 7;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_WEL_POS = 1;
    localparam int STAT_ES_POS = 2;
    localparam int STAT_PS_POS = 3;
    localparam int CLK_MHZ = 40;
    localparam int RESUME_LATENCY_US = 20;
    localparam int RESUME_CYCLES = RESUME_LATENCY_US * CLK_MHZ;
    localparam logic [4:0] BITS_ADDR_DONE = 5'h1F;
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_RESUMING = 2'b01,
        ENG_RUNNING = 2'b10
    } frp_eng_t;
endpackage : frp_pkg

// file: frp_shifter.sv
// serial byte shifter: counts bits within a select frame
`timescale 1ns/1ps
`default_nettype none
module frp_shifter (
    input wire logic clk,
    input wire logic rstN,
    input wire logic selActive,
    input wire logic sckRise,
    input wire logic mosiBit,
    output logic [31:0] shiftData,
    output logic [5:0] bitCount
);
    import frp_pkg::*;
    logic [31:0] shift_ff;
    logic [31:0] nxt_shift;
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    always_comb begin
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        if (!selActive) begin
            nxt_cnt = 6'h00;
        end else if (sckRise) begin
            nxt_shift = {shift_ff[30:0], mosiBit};
            // saturate at 63 bits, well past opcode and address, extra bytes ignored
            if (cnt_ff != 6'h3F) begin
                nxt_cnt = cnt_ff + 6'h01;
            end
        end
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            shift_ff <= 32'h0000_0000;
            cnt_ff <= 6'h00;
        end else begin
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
        end
    end
    assign shiftData = shift_ff;
    assign bitCount = cnt_ff;
endmodule // frp_shifter
`default_nettype wire

// file: frp_sync.sv
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module frp_sync (
    input wire logic clk,
    input wire logic rstN,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    logic sync_ff;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end
    assign dout = sync_ff;
endmodule // frp_sync
`default_nettype wire
